// ===== include/conv_ctrl_params.svh
// Constants of the converter control register bank.
// Assumes inclusion by the package and by both RTL modules; holds definitions, no logic.
`ifndef CONV_CTRL_PARAMS_SVH
`define CONV_CTRL_PARAMS_SVH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define FRAME_BITS 5'h18
`define CMD_BITS 5'h10
`define CMD_RW_BIT 15
`define CMD_PAGE_HI 14
`define CMD_PAGE_LO 12
`define ADDR_W 12
`define DATA_W 8

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_SOFT_RESET 12'h000
`define OFS_OUT_IF 12'h007
`define OFS_PWR_DOWN 12'h008
`define OFS_OBUF_PD 12'h009
`define OFS_SLEEP_MASK 12'h00D
`define OFS_FUSE_LOAD 12'h013

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_OUT_IF 8'h00
`define RST_PWR_DOWN 8'h02
`define RST_OBUF_PD 8'h00
`define RST_SLEEP_MASK 8'h00
`define RST_ZERO 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SOFT_RESET_BIT 0
`define FUSE_LOAD_BIT 0
`define LAYOUT_HI 7
`define LAYOUT_LO 5
`define OVERRIDE_BIT 3
`define LANE_SEL_HI 2
`define LANE_SEL_LO 0
`define PD_CLKBUF_BIT 5
`define PD_REFAMP_BIT 4
`define PD_CHAN_A_BIT 2
`define PD_SLEEP_BIT 0
`define OB_FRAME_CLK_BIT 5
`define OB_BIT_CLK_BIT 4
`define OB_LANE_A0_BIT 3
`define OB_LANE_A1_BIT 2
`define OB_LANE_B0_BIT 1
`define OB_LANE_B1_BIT 0
`define MK_CLKBUF_BIT 3
`define MK_REFAMP_BIT 2
`define MK_BANDGAP_BIT 1

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define LAYOUT_NONE 3'h0
`define LAYOUT_TWO_18_14 3'h1
`define LAYOUT_TWO_16 3'h2
`define LAYOUT_ONE 3'h3
`define LAYOUT_HALF 3'h4
`define LANE_TWO 3'h3
`define LANE_ONE 3'h4
`define LANE_HALF 3'h5

`endif

// ===== include/conv_ctrl_pkg.sv
// Types shared by the converter control register bank.
// Assumes the params header sits on the include path.
`include "conv_ctrl_params.svh"

package conv_ctrl_pkg;

   // ----------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LAYOUT_NONE_C = `LAYOUT_NONE,
      LAYOUT_TWO_18_14_C = `LAYOUT_TWO_18_14,
      LAYOUT_TWO_16_C = `LAYOUT_TWO_16,
      LAYOUT_ONE_C = `LAYOUT_ONE,
      LAYOUT_HALF_C = `LAYOUT_HALF
   } layout_code_t;

   typedef enum logic [2:0] {
      LANE_TWO_C = `LANE_TWO,
      LANE_ONE_C = `LANE_ONE,
      LANE_HALF_C = `LANE_HALF
   } lane_code_t;

   // ----------------------------------------------------------------
   // Serial port state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sclk_q;
      logic [4:0] cnt;
      logic [15:0] cmd;
      logic [7:0] dat;
      logic is_read;
      logic load;
      logic [7:0] out_sh;
      logic sdo;
      logic oe;
      logic wr;
      logic [11:0] addr;
   } port_state_t;

   // ----------------------------------------------------------------
   // Register bank state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] out_if;
      logic [7:0] pwr_down;
      logic [7:0] obuf_pd;
      logic [7:0] sleep_mask;
      logic [2:0] layout_act;
      logic [2:0] lane_fuse;
      logic load_pend;
      logic [2:0] lane_act;
      logic clkbuf_pd;
      logic refamp_pd;
      logic chan_a_pd;
      logic bandgap_pd;
      logic sleep;
      logic frame_clk_pd;
      logic bit_clk_pd;
      logic [3:0] lane_pd;
   } bank_state_t;

endpackage

// ===== verilog/serial_register_port.sv
// Serial register port: 24-bit frames, command word then one data byte.
// Assumes sen_b, sclk and sdio_in are synchronous to clk and that each
// sclk level lasts at least two clk periods.
`timescale 1ns/1ps
`include "conv_ctrl_params.svh"

module serial_register_port
   import conv_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial pins
   input wire logic sen_b,
   input wire logic sclk,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // Register side
   output logic [11:0] reg_addr,
   output logic wr_pulse,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);

   port_state_t s_q;
   port_state_t s_d;
   logic rise;
   logic fall;

   // ----------------------------------------------------------------
   // Frame sequencing
   // ----------------------------------------------------------------

   // Edge detect on the serial clock
   assign rise = sclk & ~s_q.sclk_q;
   assign fall = ~sclk & s_q.sclk_q;

   // Shift in command and data, shift out read data
   always_comb begin
      s_d = s_q;
      s_d.sclk_q = sclk;
      s_d.wr = 1'b0;
      s_d.load = 1'b0;
      if (sen_b) begin
         s_d.cnt = 5'h0;
         s_d.oe = 1'b0;
         s_d.is_read = 1'b0;
      end else begin
         if (rise && s_q.cnt != `FRAME_BITS) begin
            s_d.cnt = s_q.cnt + 5'h1;
            if (s_q.cnt < `CMD_BITS) begin
               s_d.cmd = {s_q.cmd[14:0], sdio_in};
            end else begin
               s_d.dat = {s_q.dat[6:0], sdio_in};
            end
            // Last address bit: latch address, mark read frames
            if (s_q.cnt == `CMD_BITS - 5'h1) begin
               s_d.addr = {s_q.cmd[10:0], sdio_in};
               s_d.is_read = s_q.cmd[`CMD_RW_BIT - 1];
               s_d.load = s_q.cmd[`CMD_RW_BIT - 1];
            end
            // Last data bit of a write frame with a zero page field
            if (s_q.cnt == `FRAME_BITS - 5'h1 && !s_q.cmd[`CMD_RW_BIT]
                && s_q.cmd[`CMD_PAGE_HI:`CMD_PAGE_LO] == 3'h0) begin
               s_d.wr = 1'b1;
            end
         end
         if (s_q.load) begin
            s_d.out_sh = rd_data;
         end
         // Read data leaves on falling edges, most significant first
         if (fall && s_q.is_read && s_q.cnt >= `CMD_BITS && s_q.cnt < `FRAME_BITS) begin
            s_d.sdo = s_q.out_sh[7];
            s_d.out_sh = {s_q.out_sh[6:0], 1'b0};
            s_d.oe = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs
   assign sdio_out = s_q.sdo;
   assign sdio_oe = s_q.oe;
   assign reg_addr = s_q.addr;
   assign wr_pulse = s_q.wr;
   assign wr_data = s_q.dat;

endmodule

// ===== verilog/converter_control_registers.sv
// Control register bank of a serial-output converter: soft reset,
// output layout and lane mode, power-down controls.
// Assumes fuse defaults are stable inputs and the serial pins are
// synchronous to clk.
//
// Operation
// - Writing 1 to bit 0 of the reset register restores every register default and the bit reads 0.
// - The layout field in bits 7 to 5 codes 001 two-lane 18/14 bit, 010 two-lane 16 bit, 011 one-lane, 100 half-lane.
// - A written layout code takes effect only when the fuse-load command is issued.
// - After reset the layout is loaded from fuses while the field still reads 000 until written.
// - The override enable in bit 3 gates the lane-mode select; clear means the fuse lane mode holds.
// - Lane-mode select codes 011 two-lane, 100 one-lane, 101 half-lane.
// - After reset the lane mode comes from fuses while the select field reads 000 until written.
// - Power-down bit 5 turns off the sampling clock buffer.
// - Power-down bit 4 turns off the reference gain amplifier.
// - Power-down bit 2 turns off converter channel A.
// - Power-down bit 0 enters chip sleep, with the mask register choosing what turns off.
// - Mask bit 3 keeps the clock buffer on, bit 2 the reference amp, bit 1 lets the bandgap sleep.
// - Output-buffer bit 5 turns off the frame clock buffer and bit 4 the bit clock buffer.
// - Lanes unused in one-lane and half-lane modes are turned off whatever their bits hold.
`timescale 1ns/1ps
`include "conv_ctrl_params.svh"

module converter_control_registers
   import conv_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial register port
   input wire logic sen_b,
   input wire logic sclk,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // Fuse defaults
   input wire logic [2:0] fuse_layout,
   input wire logic [2:0] fuse_lane_mode,
   // Active interface selection
   output logic [2:0] output_layout_variant,
   output logic [2:0] lane_mode_active,
   // Power-down controls
   output logic clock_buffer_pd,
   output logic reference_amp_pd,
   output logic channel_a_pd,
   output logic bandgap_pd,
   output logic chip_sleep_active,
   output logic frame_clock_buffer_pd,
   output logic bit_clock_buffer_pd,
   output logic lane_a0_buffer_pd,
   output logic lane_a1_buffer_pd,
   output logic lane_b0_buffer_pd,
   output logic lane_b1_buffer_pd
);

   bank_state_t s_q;
   bank_state_t s_d;
   logic [11:0] reg_addr;
   logic wr_pulse;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic [2:0] lane_eff;
   logic [3:0] lane_force;

   // ----------------------------------------------------------------
   // Serial port
   // ----------------------------------------------------------------

   // Frame decoding and read-data launch
   serial_register_port port (
      .clk(clk),
      .rst_b(rst_b),
      .sen_b(sen_b),
      .sclk(sclk),
      .sdio_in(sdio_in),
      .sdio_out(sdio_out),
      .sdio_oe(sdio_oe),
      .reg_addr(reg_addr),
      .wr_pulse(wr_pulse),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

   // ----------------------------------------------------------------
   // Readback
   // ----------------------------------------------------------------

   // Command registers read zero; unmapped addresses read zero
   // layout readback
   always_comb begin
      unique case (reg_addr)
         `OFS_OUT_IF: rd_data = s_q.out_if;
         `OFS_PWR_DOWN: rd_data = s_q.pwr_down;
         `OFS_OBUF_PD: rd_data = s_q.obuf_pd;
         `OFS_SLEEP_MASK: rd_data = s_q.sleep_mask;
         default: rd_data = `RST_ZERO;
      endcase
   end

   // ----------------------------------------------------------------
   // Lane selection
   // ----------------------------------------------------------------

   assign lane_eff = s_q.out_if[`OVERRIDE_BIT]
                     ? s_q.out_if[`LANE_SEL_HI:`LANE_SEL_LO] : s_q.lane_fuse;

   always_comb begin
      lane_force = 4'h0;
      unique case (lane_eff)
         `LANE_ONE: begin
            lane_force[`OB_LANE_A1_BIT] = 1'b1;
            lane_force[`OB_LANE_B1_BIT] = 1'b1;
         end
         `LANE_HALF: begin
            lane_force[`OB_LANE_A1_BIT] = 1'b1;
            lane_force[`OB_LANE_B1_BIT] = 1'b1;
            lane_force[`OB_LANE_B0_BIT] = 1'b1;
         end
         default: lane_force = 4'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------

   // Next state: writes, commands, fuse loads and derived controls
   always_comb begin
      s_d = s_q;
      if (s_q.load_pend) begin
         s_d.layout_act = fuse_layout;
         s_d.lane_fuse = fuse_lane_mode;
         s_d.load_pend = 1'b0;
      end
      if (wr_pulse) begin
         unique case (reg_addr)
            `OFS_SOFT_RESET: begin
               if (wr_data[`SOFT_RESET_BIT]) begin
                  s_d.out_if = `RST_OUT_IF;
                  s_d.pwr_down = `RST_PWR_DOWN;
                  s_d.obuf_pd = `RST_OBUF_PD;
                  s_d.sleep_mask = `RST_SLEEP_MASK;
                  s_d.load_pend = 1'b1;
               end
            end
            `OFS_OUT_IF: s_d.out_if = wr_data;
            `OFS_PWR_DOWN: s_d.pwr_down = wr_data;
            `OFS_OBUF_PD: s_d.obuf_pd = wr_data;
            `OFS_SLEEP_MASK: s_d.sleep_mask = wr_data;
            `OFS_FUSE_LOAD: begin
               if (wr_data[`FUSE_LOAD_BIT]) begin
                  s_d.layout_act = (s_q.out_if[`LAYOUT_HI:`LAYOUT_LO] != `LAYOUT_NONE)
                                   ? s_q.out_if[`LAYOUT_HI:`LAYOUT_LO] : fuse_layout;
                  s_d.lane_fuse = fuse_lane_mode;
                  s_d.pwr_down = `RST_PWR_DOWN;
                  s_d.obuf_pd = `RST_OBUF_PD;
                  s_d.sleep_mask = `RST_SLEEP_MASK;
               end
            end
            default: s_d.out_if = s_q.out_if;
         endcase
      end
      // Derived controls, registered for clean outputs
      s_d.lane_act = lane_eff;
      s_d.sleep = s_q.pwr_down[`PD_SLEEP_BIT];
      s_d.clkbuf_pd = s_q.pwr_down[`PD_CLKBUF_BIT]
                      | (s_q.pwr_down[`PD_SLEEP_BIT] & ~s_q.sleep_mask[`MK_CLKBUF_BIT]);
      s_d.refamp_pd = s_q.pwr_down[`PD_REFAMP_BIT]
                      | (s_q.pwr_down[`PD_SLEEP_BIT] & ~s_q.sleep_mask[`MK_REFAMP_BIT]);
      s_d.chan_a_pd = s_q.pwr_down[`PD_CHAN_A_BIT] | s_q.pwr_down[`PD_SLEEP_BIT];
      s_d.bandgap_pd = s_q.pwr_down[`PD_SLEEP_BIT] & s_q.sleep_mask[`MK_BANDGAP_BIT];
      s_d.frame_clk_pd = s_q.obuf_pd[`OB_FRAME_CLK_BIT];
      s_d.bit_clk_pd = s_q.obuf_pd[`OB_BIT_CLK_BIT];
      s_d.lane_pd = s_q.obuf_pd[3:0] | lane_force;
   end

   // State register; reset arms a fuse reload on the next edge
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.pwr_down <= `RST_PWR_DOWN;
         s_q.load_pend <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   assign output_layout_variant = s_q.layout_act;
   assign lane_mode_active = s_q.lane_act;
   assign clock_buffer_pd = s_q.clkbuf_pd;
   assign reference_amp_pd = s_q.refamp_pd;
   assign channel_a_pd = s_q.chan_a_pd;
   assign bandgap_pd = s_q.bandgap_pd;
   assign chip_sleep_active = s_q.sleep;
   assign frame_clock_buffer_pd = s_q.frame_clk_pd;
   assign bit_clock_buffer_pd = s_q.bit_clk_pd;
   assign lane_a0_buffer_pd = s_q.lane_pd[`OB_LANE_A0_BIT];
   assign lane_a1_buffer_pd = s_q.lane_pd[`OB_LANE_A1_BIT];
   assign lane_b0_buffer_pd = s_q.lane_pd[`OB_LANE_B0_BIT];
   assign lane_b1_buffer_pd = s_q.lane_pd[`OB_LANE_B1_BIT];

endmodule

// ===== dv/serial_controller.sv
// Serial controller model that frames register reads and writes.
// Assumes the bank samples the sclk level on the shared clk.
`timescale 1ns/1ps

module serial_controller (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic sen_b,
   output logic sclk,
   output logic sdio_in,
   input wire logic sdio_out
);
   // Idle pins: frame off, clock still
   initial begin
      sen_b = 1'b1;
      sclk = 1'b0;
      sdio_in = 1'b0;
   end

   // One 24-bit frame, MSB first, three clocks per sclk level
   task automatic xfer(input logic [23:0] fr, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge clk);
      #1 sen_b = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdio_in = fr[i];
         repeat (3) @(posedge clk);
         #1 sclk = 1'b1;
         if (i < 8) begin
            rd[i] = sdio_out;
         end
         repeat (3) @(posedge clk);
         #1 sclk = 1'b0;
      end
      repeat (3) @(posedge clk);
      #1 sen_b = 1'b1;
      // Idle data toggles so no stale level is trusted
      repeat (10) begin
         @(posedge clk);
         #1 sdio_in = ~sdio_in;
      end
   endtask

   // Register write, page bits zero
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] x;
      xfer({4'h0, a, d}, x);
   endtask

   // Register read
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      xfer({4'h8, a, 8'h00}, d);
   endtask
endmodule

// ===== dv/conv_ctrl_chk.sv
// Port checker of the converter control register bank.
// Assumes one clock domain; bound to the bank below.
`timescale 1ns/1ps

module conv_ctrl_chk
   import conv_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial and fuse inputs
   input wire logic sen_b,
   input wire logic sdio_oe,
   input wire logic [2:0] fuse_layout,
   input wire logic [2:0] fuse_lane_mode,
   // Bank outputs
   input wire logic [2:0] output_layout_variant,
   input wire logic [2:0] lane_mode_active,
   input wire logic clock_buffer_pd,
   input wire logic reference_amp_pd,
   input wire logic channel_a_pd,
   input wire logic bandgap_pd,
   input wire logic chip_sleep_active,
   input wire logic frame_clock_buffer_pd,
   input wire logic bit_clock_buffer_pd,
   input wire logic lane_a1_buffer_pd,
   input wire logic lane_b0_buffer_pd,
   input wire logic lane_b1_buffer_pd
);
   logic [6:0] pwr;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Power outputs gathered
   assign pwr = {clock_buffer_pd, reference_amp_pd, channel_a_pd, bandgap_pd,
      chip_sleep_active, frame_clock_buffer_pd, bit_clock_buffer_pd};

   AST_BANDGAP_SLEEP: assert property (bandgap_pd |-> chip_sleep_active)
      else $error("bandgap off outside sleep");
   AST_SLEEP_CHAN: assert property (chip_sleep_active |-> channel_a_pd)
      else $error("channel running in sleep");
   AST_HALF_LANES: assert property ((lane_mode_active == LANE_HALF_C) [*3]
      |-> lane_a1_buffer_pd && lane_b0_buffer_pd && lane_b1_buffer_pd)
      else $error("unused lane on in half mode");
   AST_ONE_LANES: assert property ((lane_mode_active == LANE_ONE_C) [*3]
      |-> lane_a1_buffer_pd && lane_b1_buffer_pd)
      else $error("unused lane on in one mode");
   AST_FUSE_START: assert property ($rose(rst_b) |-> ##2
      output_layout_variant == fuse_layout && lane_mode_active == fuse_lane_mode)
      else $error("fuse defaults not taken");
   AST_RESET_PWR: assert property ($rose(rst_b) |-> ##1 pwr == 7'h00)
      else $error("power controls not at default");
   AST_IDLE_HOLD: assert property (sen_b [*8] |-> $stable(pwr))
      else $error("power control moved without frame");
   AST_OE_DROP: assert property ($rose(sen_b) |-> ##2 !sdio_oe)
      else $error("data line driven after frame");
endmodule

bind converter_control_registers conv_ctrl_chk chk_u (.clk(clk), .rst_b(rst_b),
   .sen_b(sen_b), .sdio_oe(sdio_oe), .fuse_layout(fuse_layout),
   .fuse_lane_mode(fuse_lane_mode), .output_layout_variant(output_layout_variant),
   .lane_mode_active(lane_mode_active), .clock_buffer_pd(clock_buffer_pd),
   .reference_amp_pd(reference_amp_pd), .channel_a_pd(channel_a_pd),
   .bandgap_pd(bandgap_pd), .chip_sleep_active(chip_sleep_active),
   .frame_clock_buffer_pd(frame_clock_buffer_pd),
   .bit_clock_buffer_pd(bit_clock_buffer_pd), .lane_a1_buffer_pd(lane_a1_buffer_pd),
   .lane_b0_buffer_pd(lane_b0_buffer_pd), .lane_b1_buffer_pd(lane_b1_buffer_pd));

// ===== dv/test_converter_control_registers.sv
// Testbench of the converter control register bank.
// Assumes the serial controller model drives the register port.
`timescale 1ns/1ps

module test_converter_control_registers
   import conv_ctrl_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] fuse_layout = 3'h2;
   logic [2:0] fuse_lane_mode = 3'h3;
   logic sen_b, sclk, sdio_in, sdio_out, sdio_oe;
   logic cb, ra, ca, bg, sl, fc, bc, a0, a1, b0, b1;
   logic [2:0] lay, lane;
   logic [7:0] scratch;
   int n_mismatch = 0;
   int check_count = 0;
   logic [11:0] ofs [5] = '{12'h000, 12'h007, 12'h008, 12'h009, 12'h00D};
   logic [7:0] dflt [5] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
   logic [11:0] pa [6] = '{12'h008, 12'h008, 12'h008, 12'h008, 12'h00D, 12'h009};
   logic [7:0] pd [6] = '{8'h22, 8'h12, 8'h06, 8'h03, 8'h0E, 8'h30};
   logic [7:0] pe [6] = '{8'h40, 8'h20, 8'h10, 8'h74, 8'h1C, 8'h1F};
   wire [7:0] pv = {1'b0, cb, ra, ca, bg, sl, fc, bc};
   wire [7:0] lv = {4'h0, a0, a1, b0, b1};
   wire [7:0] mv = {2'h0, lay, lane};

   always #4 clk = ~clk;

   // Bank and controller
   converter_control_registers dut_u (.clk(clk), .rst_b(rst_b), .sen_b(sen_b),
      .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .fuse_layout(fuse_layout), .fuse_lane_mode(fuse_lane_mode),
      .output_layout_variant(lay), .lane_mode_active(lane), .clock_buffer_pd(cb),
      .reference_amp_pd(ra), .channel_a_pd(ca), .bandgap_pd(bg), .chip_sleep_active(sl),
      .frame_clock_buffer_pd(fc), .bit_clock_buffer_pd(bc), .lane_a0_buffer_pd(a0),
      .lane_a1_buffer_pd(a1), .lane_b0_buffer_pd(b0), .lane_b1_buffer_pd(b1));
   // Released data line shows the inverse, so a missing enable reads wrong
   serial_controller ctl_u (.clk(clk), .sen_b(sen_b), .sclk(sclk), .sdio_in(sdio_in),
      .sdio_out(sdio_oe ? sdio_out : ~sdio_out));

   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Read a register and compare
   task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] d;
      ctl_u.rd(a, d);
      chk(d, exp);
   endtask

   // Verdict and end of run
   task automatic close_out();
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      foreach (ofs[i]) rchk(ofs[i], dflt[i]);
      chk(mv, {2'h0, 3'h2, 3'h3});
      ctl_u.wr(12'h007, 8'h8D);
      rchk(12'h007, 8'h8D);
      chk(mv, {2'h0, 3'h2, 3'h5});
      ctl_u.wr(12'h013, 8'h01);
      chk(mv, {2'h0, 3'h4, 3'h5});
      ctl_u.wr(12'h007, 8'h64);
      chk(mv, {2'h0, 3'h4, 3'h3});
      for (int i = 3; i < 6; i++) begin
         ctl_u.wr(12'h007, {5'h01, i[2:0]});
         chk(mv, {2'h0, 3'h4, i[2:0]});
         chk(lv, (i == 4) ? 8'h05 : (i == 5) ? 8'h07 : 8'h00);
      end
      ctl_u.wr(12'h009, 8'h08);
      chk(lv, 8'h0F);
      for (int i = 0; i < 5; i++) begin
         ctl_u.wr(12'h007, {i[2:0], 5'h00});
         ctl_u.wr(12'h013, 8'h01);
         chk({5'h00, lay}, (i == 0) ? 8'h02 : 8'(i));
      end
      for (int i = 0; i < 6; i++) begin
         ctl_u.wr(pa[i], pd[i]);
         chk(pv, pe[i]);
      end
      // Write with a nonzero page field is refused
      ctl_u.xfer({4'h1, 12'h009, 8'hFF}, scratch);
      rchk(12'h009, 8'h30);
      // Unmapped place reads zero
      ctl_u.wr(12'h00A, 8'h55);
      rchk(12'h00A, 8'h00);
      ctl_u.wr(12'h000, 8'h01);
      chk(pv, 8'h00);
      chk(mv, {2'h0, 3'h2, 3'h3});
      foreach (ofs[i]) rchk(ofs[i], dflt[i]);
      close_out();
   end
endmodule
